// ===== core/pbc_pkg.sv
package pbc_pkg;

   // ==========================================================
   // register addresses on the management serial port
   localparam logic [4:0]  REG_BYPASS      = 5'h12;
   localparam logic [4:0]  REG_RX_ERR      = 5'h13;
   localparam logic [4:0]  REG_FALSE_CAR   = 5'h14;
   localparam logic [4:0]  REG_LINK_DROP   = 5'h15;

   // ==========================================================
   // bypass_control layout
   localparam logic [15:0] BYPASS_RST      = 16'h0088;
   localparam logic [15:0] BYPASS_WMASK    = 16'hFEFE;
   localparam logic [15:0] BYPASS_STICKY   = 16'h00FA;
   localparam int unsigned BIT_TX_DIS      = 15;
   localparam int unsigned BIT_BYP_4B5B    = 14;
   localparam int unsigned BIT_BYP_SCR     = 13;
   localparam int unsigned BIT_BYP_DESCR   = 12;
   localparam int unsigned BIT_BYP_PCS_RX  = 11;
   localparam int unsigned BIT_BYP_PCS_TX  = 10;
   localparam int unsigned BIT_BYP_LFI     = 9;
   localparam int unsigned BIT_XOVER_OFF   = 7;
   localparam int unsigned BIT_LEGACY_OFF  = 6;
   localparam int unsigned BIT_PSWAP_OFF   = 5;
   localparam int unsigned BIT_POL_OFF     = 4;
   localparam int unsigned BIT_PDET_HONOR  = 3;
   localparam int unsigned BIT_SHAPE_OFF   = 2;
   localparam int unsigned BIT_AUTO_NP_OFF = 1;

   // ==========================================================
   // error counters
   localparam int unsigned CNT_W           = 8;
   localparam logic [7:0]  CNT_MAX         = 8'hFF;
   localparam logic [7:0]  CNT_RST         = 8'h00;
   localparam logic [7:0]  CNT_PAD         = 8'h00;
   localparam logic [7:0]  CNT_ONE         = 8'h01;

   // ==========================================================
   // serial frame timing, in management clock bits
   localparam logic [5:0]  PRE_LEN         = 6'h20;
   localparam logic [5:0]  HDR_LAST        = 6'h0B;
   localparam logic [5:0]  TA_LAST         = 6'h01;
   localparam logic [5:0]  DATA_LAST       = 6'h0F;
   localparam logic [5:0]  CNT_ZERO        = 6'h00;
   localparam logic [5:0]  CNT_STEP        = 6'h01;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_WRITE        = 2'h1;

   typedef enum logic [2:0] {
      MS_IDLE  = 3'b000,
      MS_START = 3'b001,
      MS_HDR   = 3'b010,
      MS_TA    = 3'b011,
      MS_WDATA = 3'b100,
      MS_RDATA = 3'b101
   } pbc_mstate_t;

   // decoded control towards the datapath
   typedef struct packed {
      logic tx_disable;
      logic bypass_4b5b;
      logic bypass_scrambler;
      logic bypass_descrambler;
      logic bypass_pcs_rx;
      logic bypass_pcs_tx;
      logic bypass_link_fail_inhibit_timer;
      logic automatic_crossover_off_forced;
      logic legacy_partner_detect_off;
      logic pair_swap_fix_off;
      logic polarity_fix_off;
      logic parallel_detect_honor;
      logic pulse_shaping_off;
      logic auto_next_page_off;
   } pbc_bypass_t;

   // one-cycle datapath events
   typedef struct packed {
      logic rx_error;
      logic false_carrier;
      logic link_drop;
   } pbc_evt_t;

   typedef struct packed {
      logic s1;
      logic s2;
   } pbc_sync_state_t;

   typedef struct packed {
      logic [7:0] count;
   } pbc_cnt_state_t;

endpackage

// ===== core/pbc_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for a pin level
module pbc_sync2 (
   input  wire logic sys_clk,   // system clock
   input  wire logic arst_n,    // async reset, low
   input  wire logic pin,       // asynchronous level
   output logic      level      // synchronised level
);
   pbc_pkg::pbc_sync_state_t st;
   pbc_pkg::pbc_sync_state_t nx;

   // first stage feeds only the second
   always_comb begin
      nx    = st;
      nx.s1 = pin;
      nx.s2 = st.s1;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign level = st.s2;
endmodule

// ===== core/pbc_sat_counter.sv
`timescale 1ns/1ps
// ==========================================================
// saturating event counter, cleared by a read
module pbc_sat_counter (
   input  wire logic       sys_clk,   // system clock
   input  wire logic       arst_n,    // async reset, low
   input  wire logic       evt,       // one-cycle event
   input  wire logic       clr,       // read taken, clear
   output logic [7:0]      count      // current value
);
   pbc_pkg::pbc_cnt_state_t st;
   pbc_pkg::pbc_cnt_state_t nx;

   // an event in the clearing cycle counts as one, never lost
   always_comb begin
      nx = st;
      if (clr) begin
         nx.count = evt ? pbc_pkg::CNT_ONE : pbc_pkg::CNT_RST;  // R19
      end else if (evt && st.count != pbc_pkg::CNT_MAX) begin
         nx.count = st.count + pbc_pkg::CNT_ONE;                // R18
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st.count <= pbc_pkg::CNT_RST;                          // R19
      end else begin
         st <= nx;
      end
   end

   assign count = st.count;
endmodule

// ===== core/pbc_bypass_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R1: bit 15 disables line transmitter
// R2: bit 14 bypasses 4B/5B coding stages
// R3: bits 13,12,11 bypass scrambler, descrambler, PCS rx
// R4: bit 10 bypasses PCS transmit path
// R5: bit 9 bypasses link fail inhibit timer
// R6: bit 7, default one, stops forced crossover
// R7: bit 6 stops legacy gigabit partner detect
// R8: bit 5 stops pair swap correction
// R9: bit 4 stops polarity inversion correction
// R10: bit 3, default one, honours advertised ability
// R11: bit 2 disables transmit pulse shaping
// R12: bit 1 stops automatic next pages
// R13: then hand control to station after base page
// R14: station sends next pages, forces configuration
// R15: receive error count in register 19 low byte
// R16: false carrier count in register 20
// R17: link disconnect count in register 21
// R18: counters eight bits, saturate at 255
// R19: read returns value then clears; reset zero
// R20: sticky bits survive port soft reset
// R21: reserved bits read zero, ignore writes
module pbc_bypass_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h00   // port address
) (
   input  wire logic               sys_clk,        // 20 MHz clock
   input  wire logic               arst_n,         // async reset, low
   input  wire logic               soft_rst,       // port soft reset
   input  wire logic               mdc,            // management clock pin
   input  wire logic               mdio_i,         // management data in
   output logic                    mdio_o,         // management data out
   output logic                    mdio_oe_n,      // drive enable, low
   input  wire pbc_pkg::pbc_evt_t  evt,            // datapath events
   input  wire logic               base_page_done, // base page exchanged
   output pbc_pkg::pbc_bypass_t    bypass_cfg,     // decoded control
   output logic                    page_handover   // station owns pages
);

   // ==========================================================
   // state
   typedef struct packed {
      pbc_pkg::pbc_mstate_t fsm;
      logic [5:0]           cnt;
      logic [15:0]          shreg;
      logic [4:0]           addr;
      logic                 hit;
      logic                 rd;
      logic                 mdc_prev;
      logic [15:0]          bypass_reg;
      logic                 handover;
      logic                 mdio_out;
      logic                 mdio_oe_n;
   } pbc_state_t;

   pbc_state_t  st;
   pbc_state_t  nx;
   logic        mdc_s;
   logic        mdio_s;
   logic        rise;
   logic [2:0]  clr_now;
   logic [7:0]  cnt_rx_err;
   logic [7:0]  cnt_false_car;
   logic [7:0]  cnt_link_drop;
   logic [11:0] hdr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rmapped;

   // ==========================================================
   // pin synchronisers
   pbc_sync2 u_sync_mdc (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .pin     (mdc),
      .level   (mdc_s)
   );

   pbc_sync2 u_sync_mdio (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .pin     (mdio_i),
      .level   (mdio_s)
   );

   // ==========================================================
   // error counters
   pbc_sat_counter u_cnt_rx_err (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .evt     (evt.rx_error),          // R15
      .clr     (clr_now[0]),
      .count   (cnt_rx_err)
   );

   pbc_sat_counter u_cnt_false_car (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .evt     (evt.false_carrier),     // R16
      .clr     (clr_now[1]),
      .count   (cnt_false_car)
   );

   pbc_sat_counter u_cnt_link_drop (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .evt     (evt.link_drop),         // R17
      .clr     (clr_now[2]),
      .count   (cnt_link_drop)
   );

   // ==========================================================
   // frame fields and read mux
   assign rise  = mdc_s & ~st.mdc_prev;
   assign hdr   = {st.shreg[10:0], mdio_s};
   assign wdata = {st.shreg[14:0], mdio_s};

   // counters read with a zero upper byte
   always_comb begin
      rdata   = 16'h0000;
      rmapped = 1'b1;
      unique case (hdr[4:0])
         pbc_pkg::REG_BYPASS:    rdata = st.bypass_reg;
         pbc_pkg::REG_RX_ERR:    rdata = {pbc_pkg::CNT_PAD, cnt_rx_err};
         pbc_pkg::REG_FALSE_CAR: rdata = {pbc_pkg::CNT_PAD, cnt_false_car};
         pbc_pkg::REG_LINK_DROP: rdata = {pbc_pkg::CNT_PAD, cnt_link_drop};
         default:                rmapped = 1'b0;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      nx          = st;
      clr_now     = 3'h0;
      nx.mdc_prev = mdc_s;

      // all frame work happens on a rising management clock
      if (rise) begin
         unique case (st.fsm)
            // count preamble ones; a zero after 32 opens a frame
            pbc_pkg::MS_IDLE: begin
               if (mdio_s) begin
                  if (st.cnt != pbc_pkg::PRE_LEN) begin
                     nx.cnt = st.cnt + pbc_pkg::CNT_STEP;
                  end
               end else if (st.cnt == pbc_pkg::PRE_LEN) begin
                  nx.fsm = pbc_pkg::MS_START;
               end else begin
                  nx.cnt = pbc_pkg::CNT_ZERO;
               end
            end
            // second start bit must be one
            pbc_pkg::MS_START: begin
               nx.cnt = pbc_pkg::CNT_ZERO;
               nx.fsm = mdio_s ? pbc_pkg::MS_HDR : pbc_pkg::MS_IDLE;
            end
            // op, port address, register address
            pbc_pkg::MS_HDR: begin
               nx.shreg = {st.shreg[14:0], mdio_s};
               nx.cnt   = st.cnt + pbc_pkg::CNT_STEP;
               if (st.cnt == pbc_pkg::HDR_LAST) begin
                  nx.cnt  = pbc_pkg::CNT_ZERO;
                  nx.addr = hdr[4:0];
                  nx.fsm  = pbc_pkg::MS_TA;
                  nx.hit  = (hdr[9:5] == PHY_ADDR) &&
                            (hdr[11:10] == pbc_pkg::OP_READ ||
                             hdr[11:10] == pbc_pkg::OP_WRITE);
                  if (hdr[9:5] == PHY_ADDR &&
                      hdr[11:10] == pbc_pkg::OP_READ) begin
                     // snapshot and clear in one edge: no event slips
                     nx.shreg = rdata;
                     nx.hit   = rmapped;
                     clr_now[0] = rmapped &&
                        hdr[4:0] == pbc_pkg::REG_RX_ERR;    // R19
                     clr_now[1] = rmapped &&
                        hdr[4:0] == pbc_pkg::REG_FALSE_CAR; // R19
                     clr_now[2] = rmapped &&
                        hdr[4:0] == pbc_pkg::REG_LINK_DROP; // R19
                  end else if (hdr[11:10] != pbc_pkg::OP_WRITE) begin
                     nx.hit = 1'b0;
                  end
                  // direction kept apart from data, which may hold anything
                  nx.rd = hdr[11:10] == pbc_pkg::OP_READ;
               end
            end
            // turnaround: on reads drive the zero in its second bit
            pbc_pkg::MS_TA: begin
               nx.cnt = st.cnt + pbc_pkg::CNT_STEP;
               // only an accepted read drives; refused frames stay off
               if (st.cnt == pbc_pkg::CNT_ZERO && st.hit && st.rd) begin
                  nx.mdio_out  = 1'b0;
                  nx.mdio_oe_n = 1'b0;
               end
               if (st.cnt == pbc_pkg::TA_LAST) begin
                  nx.cnt = pbc_pkg::CNT_ZERO;
                  nx.fsm = st.mdio_oe_n ? pbc_pkg::MS_WDATA
                                        : pbc_pkg::MS_RDATA;
                  if (!st.mdio_oe_n) begin
                     nx.mdio_out = st.shreg[15];
                     nx.shreg    = {st.shreg[14:0], 1'b0};
                  end
               end
            end
            // sixteen write bits, committed on the last
            pbc_pkg::MS_WDATA: begin
               nx.shreg = wdata;
               nx.cnt   = st.cnt + pbc_pkg::CNT_STEP;
               if (st.cnt == pbc_pkg::DATA_LAST) begin
                  nx.cnt = pbc_pkg::CNT_ZERO;
                  nx.fsm = pbc_pkg::MS_IDLE;
                  if (st.hit && !st.rd &&
                      st.addr == pbc_pkg::REG_BYPASS) begin
                     nx.bypass_reg = wdata & pbc_pkg::BYPASS_WMASK; // R21
                  end
               end
            end
            // sixteen read bits, msb first, then release
            pbc_pkg::MS_RDATA: begin
               nx.cnt      = st.cnt + pbc_pkg::CNT_STEP;
               nx.mdio_out = st.shreg[15];
               nx.shreg    = {st.shreg[14:0], 1'b0};
               if (st.cnt == pbc_pkg::DATA_LAST) begin
                  nx.cnt       = pbc_pkg::CNT_ZERO;
                  nx.fsm       = pbc_pkg::MS_IDLE;
                  nx.mdio_out  = 1'b0;
                  nx.mdio_oe_n = 1'b1;
               end
            end
            default: begin
               nx.fsm       = pbc_pkg::MS_IDLE;
               nx.cnt       = pbc_pkg::CNT_ZERO;
               nx.mdio_oe_n = 1'b1;
            end
         endcase
      end

      // soft reset restores only the non-sticky bits
      if (soft_rst) begin
         nx.bypass_reg = (nx.bypass_reg & pbc_pkg::BYPASS_STICKY) | // R20
                         (pbc_pkg::BYPASS_RST & ~pbc_pkg::BYPASS_STICKY);
         nx.handover   = 1'b0;
      end

      // station owns page exchange until it re-enables auto pages
      if (!st.bypass_reg[pbc_pkg::BIT_AUTO_NP_OFF]) begin
         nx.handover = 1'b0;
      end
      if (base_page_done && st.bypass_reg[pbc_pkg::BIT_AUTO_NP_OFF]) begin
         nx.handover = 1'b1;                                    // R13
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st            <= '0;
         st.fsm        <= pbc_pkg::MS_IDLE;
         st.bypass_reg <= pbc_pkg::BYPASS_RST;                  // R6 R10
         st.mdio_oe_n  <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   // ==========================================================
   // outputs, straight from state
   assign mdio_o        = st.mdio_out;
   assign mdio_oe_n     = st.mdio_oe_n;
   assign page_handover = st.handover;
   // datapath stage bypasses, plain bits
   assign bypass_cfg.tx_disable =
      st.bypass_reg[pbc_pkg::BIT_TX_DIS];          // R1
   assign bypass_cfg.bypass_4b5b =
      st.bypass_reg[pbc_pkg::BIT_BYP_4B5B];        // R2
   assign bypass_cfg.bypass_scrambler =
      st.bypass_reg[pbc_pkg::BIT_BYP_SCR];         // R3
   assign bypass_cfg.bypass_descrambler =
      st.bypass_reg[pbc_pkg::BIT_BYP_DESCR];       // R3
   assign bypass_cfg.bypass_pcs_rx =
      st.bypass_reg[pbc_pkg::BIT_BYP_PCS_RX];      // R3
   assign bypass_cfg.bypass_pcs_tx =
      st.bypass_reg[pbc_pkg::BIT_BYP_PCS_TX];      // R4
   assign bypass_cfg.bypass_link_fail_inhibit_timer =
      st.bypass_reg[pbc_pkg::BIT_BYP_LFI];         // R5
   // correction and negotiation controls, mostly sticky
   assign bypass_cfg.automatic_crossover_off_forced =
      st.bypass_reg[pbc_pkg::BIT_XOVER_OFF];       // R6
   assign bypass_cfg.legacy_partner_detect_off =
      st.bypass_reg[pbc_pkg::BIT_LEGACY_OFF];      // R7
   assign bypass_cfg.pair_swap_fix_off =
      st.bypass_reg[pbc_pkg::BIT_PSWAP_OFF];       // R8
   assign bypass_cfg.polarity_fix_off =
      st.bypass_reg[pbc_pkg::BIT_POL_OFF];         // R9
   assign bypass_cfg.parallel_detect_honor =
      st.bypass_reg[pbc_pkg::BIT_PDET_HONOR];      // R10
   assign bypass_cfg.pulse_shaping_off =
      st.bypass_reg[pbc_pkg::BIT_SHAPE_OFF];       // R11
   assign bypass_cfg.auto_next_page_off =
      st.bypass_reg[pbc_pkg::BIT_AUTO_NP_OFF];     // R12
endmodule

// ===== bench/pbc_checker.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the bypass register, page handover and mdio timing
module pbc_checker (
   input wire logic                 sys_clk,        // system clock
   input wire logic                 arst_n,         // async reset, low
   input wire logic                 soft_rst,       // port soft reset
   input wire logic                 mdc,            // management clock
   input wire logic                 mdio_o,         // device data
   input wire logic                 mdio_oe_n,      // device enable, low
   input wire logic                 base_page_done, // base page done
   input wire pbc_pkg::pbc_bypass_t bypass_cfg,     // decoded control
   input wire logic                 page_handover   // station owns pages
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   logic [13:0] cfg;
   // flat view: sticky 0x007D, plain 0x3F82
   assign cfg = bypass_cfg;

   sequence s_ho_trig;
      base_page_done && cfg[0];
   endsequence
   sequence s_soft;
      soft_rst && !base_page_done;
   endsequence
   property p_rst_cfg;
      !$past(arst_n) |-> cfg == 14'h0044;
   endproperty
   property p_soft_clr;
      s_soft |=> (cfg & 14'h3F82) == 14'h0000 && !page_handover;
   endproperty
   property p_soft_keep;
      soft_rst |=> (cfg & 14'h007D) == ($past(cfg) & 14'h007D);
   endproperty
   property p_ho_set;
      s_ho_trig |=> page_handover;
   endproperty
   property p_ho_clr;
      !cfg[0] |=> !page_handover;
   endproperty
   property p_ho_cause;
      $rose(page_handover) |-> $past(base_page_done) && $past(cfg[0]);
   endproperty
   // writes land a few cycles after a rising mdc, while it is still high
   property p_cfg_when;
      $changed(cfg) && !$past(soft_rst) |-> mdc;
   endproperty
   property p_drive_when;
      $changed(mdio_oe_n) |-> mdc;
   endproperty
   property p_data_when;
      !mdio_oe_n && $changed(mdio_o) |-> mdc;
   endproperty
   property p_ta_zero;
      $fell(mdio_oe_n) |-> !mdio_o;
   endproperty

   a_rst_cfg: assert property (p_rst_cfg)
      else $error("control not at reset value");
   a_soft_clr: assert property (p_soft_clr)
      else $error("plain bits kept over soft reset");
   a_soft_keep: assert property (p_soft_keep)
      else $error("sticky bits lost over soft reset");
   a_ho_set: assert property (p_ho_set)
      else $error("handover not raised");
   a_ho_clr: assert property (p_ho_clr)
      else $error("handover held without bit 1");
   a_ho_cause: assert property (p_ho_cause)
      else $error("handover raised without cause");
   a_cfg_when: assert property (p_cfg_when)
      else $error("control changed outside a write");
   a_drive_when: assert property (p_drive_when)
      else $error("drive enable moved off mdc");
   a_data_when: assert property (p_data_when)
      else $error("read data moved off mdc");
   a_ta_zero: assert property (p_ta_zero)
      else $error("turnaround not driven low");
endmodule

// ===== bench/pbc_station.sv
`timescale 1ns/1ps
// ==========================================================
// management station on the serial management pins
module pbc_station #(
   parameter int HALF = 10   // sys_clk cycles per mdc half
) (
   input  wire logic sys_clk,  // system clock
   input  wire logic dev_o,    // device data
   input  wire logic dev_oe_n, // device enable, low
   output logic      mdc,      // management clock
   output logic      line      // resolved data line
);
   logic st_d;
   logic st_oe_n;
   logic ta_seen;
   // pull-up wins wherever nobody drives
   assign line = (dev_oe_n | dev_o) & (st_oe_n | st_d);
   initial begin
      mdc = 1'b0;
      st_d = 1'b1;
      st_oe_n = 1'b1;
      ta_seen = 1'b1;
   end
   // one whole frame; mdc stands low between frames
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         @(posedge sys_clk);
         #1;
         mdc = 1'b0;
         st_oe_n = (op != pbc_pkg::OP_WRITE) && (i < 18);
         st_d = f[i];
         repeat (HALF) @(posedge sys_clk);
         #1;
         if (i == 16) begin
            ta_seen = line;
         end
         if (i < 16) begin
            rd = {rd[14:0], line};
         end
         mdc = 1'b1;
         repeat (HALF - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      #1;
      mdc = 1'b0;
      st_oe_n = 1'b1;
   endtask
endmodule

// ===== bench/phy_bypass_and_error_counters_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench of the bypass and counter registers
module phy_bypass_and_error_counters_tb_top;
   localparam logic [4:0] PA = 5'h05;
   logic                 sys_clk = 1'b0;
   logic                 arst_n = 1'b0;
   logic                 soft_rst = 1'b0;
   logic                 base_page_done = 1'b0;
   pbc_pkg::pbc_evt_t    evt = 3'b000;
   logic                 mdc;
   logic                 line;
   logic                 mdio_o;
   logic                 mdio_oe_n;
   logic                 page_handover;
   pbc_pkg::pbc_bypass_t bypass_cfg;
   logic [15:0]          rd;
   int                   err_count = 0;
   int                   cmp_count = 0;

   always #25 sys_clk = ~sys_clk;

   pbc_bypass_regs #(.PHY_ADDR(PA)) dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .soft_rst(soft_rst),
      .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
      .mdio_oe_n(mdio_oe_n), .evt(evt),
      .base_page_done(base_page_done), .bypass_cfg(bypass_cfg),
      .page_handover(page_handover));
   pbc_station st (.sys_clk(sys_clk), .dev_o(mdio_o),
      .dev_oe_n(mdio_oe_n), .mdc(mdc), .line(line));

   // ==========================================================
   // shared helpers
   task automatic check(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp,
         input string what);
      st.xfer(pbc_pkg::OP_READ, PA, ra, 16'h0000, rd);
      check(what, exp, rd);
   endtask
   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
      st.xfer(pbc_pkg::OP_WRITE, PA, ra, wd, rd);
   endtask
   // one strobe held for n cycles, n counts
   task automatic pulse(input logic [2:0] v, input int n);
      @(posedge sys_clk);
      #1;
      evt = v;
      repeat (n) @(posedge sys_clk);
      #1;
      evt = 3'b000;
   endtask
   task automatic tick(ref logic s);
      @(posedge sys_clk);
      #1;
      s = 1'b1;
      @(posedge sys_clk);
      #1;
      s = 1'b0;
   endtask
   function automatic logic [15:0] pack(input logic [15:0] v);
      return {2'b00, v[15:9], v[7:1]};
   endfunction

   // ==========================================================
   // scenarios
   task automatic t_reset;
      check("cfg", 16'h0044, {2'b00, bypass_cfg});
      rd_reg(pbc_pkg::REG_BYPASS, 16'h0088, "ctl");
      check("ta", 16'h0000, {15'h0000, st.ta_seen});
      for (int k = 0; k < 3; k++) begin
         rd_reg(pbc_pkg::REG_RX_ERR + 5'(k), 16'h0000, "cnt");
      end
      $display("test reset done");
   endtask
   task automatic t_bits;
      logic [15:0] v;
      for (int i = 1; i < 16; i++) begin
         v = 16'h0001 << i;
         if (i != 8) begin
            wr_reg(pbc_pkg::REG_BYPASS, v);
            check("cfg bit", pack(v), {2'b00, bypass_cfg});
         end
      end
      wr_reg(pbc_pkg::REG_BYPASS, 16'hFFFF);
      rd_reg(pbc_pkg::REG_BYPASS, 16'hFEFE, "ctl all");
      $display("test bits done");
   endtask
   // soft reset keeps sticky bits, hard reset restores all
   task automatic t_soft;
      tick(soft_rst);
      rd_reg(pbc_pkg::REG_BYPASS, 16'h00FA, "soft");
      @(posedge sys_clk);
      #1;
      arst_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      check("cfg hard", 16'h0044, {2'b00, bypass_cfg});
      rd_reg(pbc_pkg::REG_BYPASS, 16'h0088, "hard");
      $display("test soft done");
   endtask
   task automatic t_page;
      tick(base_page_done);
      check("no ho", 16'h0000, {15'h0000, page_handover});
      wr_reg(pbc_pkg::REG_BYPASS, 16'h0002);
      tick(base_page_done);
      check("ho", 16'h0001, {15'h0000, page_handover});
      wr_reg(pbc_pkg::REG_BYPASS, 16'h0000);
      check("ho off", 16'h0000, {15'h0000, page_handover});
      $display("test page done");
   endtask
   task automatic t_cnt;
      logic [4:0] ra;
      for (int k = 0; k < 3; k++) begin
         ra = pbc_pkg::REG_RX_ERR + 5'(k);
         wr_reg(ra, 16'h00AA);
         pulse(3'b100 >> k, 3 + k);
         rd_reg(ra, 16'h0003 + 16'(k), "count");
         rd_reg(ra, 16'h0000, "cleared");
      end
      pulse(3'b111, 300);
      for (int k = 0; k < 3; k++) begin
         rd_reg(pbc_pkg::REG_RX_ERR + 5'(k), 16'h00FF, "sat");
      end
      $display("test counters done");
   endtask
   // foreign address, unmapped register, unknown op: line stays high
   task automatic t_refuse;
      st.xfer(pbc_pkg::OP_READ, 5'h1F, 5'h12, 16'h0000, rd);
      check("other addr", 16'hFFFF, rd);
      rd_reg(5'h16, 16'hFFFF, "unmapped");
      st.xfer(2'b11, PA, 5'h12, 16'h0000, rd);
      check("bad op", 16'hFFFF, rd);
      $display("test refuse done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      t_reset();
      t_bits();
      t_soft();
      t_page();
      t_cnt();
      t_refuse();
      conclude();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      err_count++;
      conclude();
   end
endmodule

bind pbc_bypass_regs pbc_checker chk (
   .sys_clk(sys_clk), .arst_n(arst_n), .soft_rst(soft_rst),
   .mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
   .base_page_done(base_page_done), .bypass_cfg(bypass_cfg),
   .page_handover(page_handover));
